/* File: logic/sep_regs.svh */
// Opcodes, status layout, guard ranges and write-cycle timing of the serial memory block.
`ifndef SEP_REGS_SVH
`define SEP_REGS_SVH
`define SEP_OP_WR_ENABLE  8'h06
`define SEP_OP_WR_DISABLE 8'h04
`define SEP_OP_STAT_RD    8'h05
`define SEP_OP_STAT_WR    8'h01
`define SEP_OP_READ       8'h03
`define SEP_OP_WRITE      8'h02
`define SEP_LAST_BYTE_BIT 5'h07
`define SEP_LAST_ADDR_BIT 5'h17
`define SEP_ARRAY_TOP     18'h3ffff
`define SEP_QTR_BASE      18'h30000
`define SEP_HALF_BASE     18'h20000
`define SEP_BG_QUARTER    2'h1
`define SEP_BG_HALF       2'h2
`define SEP_BG_FULL       2'h3
`define SEP_ST_GPE        7
`define SEP_ST_PAGE_SEL   6
`define SEP_ST_FAST       5
`define SEP_ST_LOCK       4
`define SEP_ST_BG_HI      3
`define SEP_ST_BG_LO      2
`define SEP_PINS_IDLE     4'h5
`define SEP_WC_STD_MS     10
`define SEP_WC_FAST_MS    3
`define SEP_CLK_KHZ       100000
`define SEP_CYC_W         20
`define SEP_FIFO_DEPTH    2'h2
`endif

/* File: logic/sep_pkg.sv */
// Types shared by the serial memory block: pin group, status layout and command states.
`default_nettype none
package sep_pkg;
  typedef struct packed {
    logic sck;
    logic cs_n;
    logic si;
    logic wp_n;
  } sep_pins_t;

  typedef struct packed {
    logic guard_pin_enable;
    logic id_page_select;
    logic fast_program_select;
    logic id_page_lock;
    logic block_guard_hi;
    logic block_guard_lo;
    logic write_enable_latch;
    logic busy;
  } sep_status_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_OP     = 4'b0001,
    ST_ADDR   = 4'b0010,
    ST_WDATA  = 4'b0011,
    ST_RDATA  = 4'b0100,
    ST_SRDATA = 4'b0101,
    ST_SRWR   = 4'b0110,
    ST_CMD_WRITE_ENABLE   = 4'b0111,
    ST_IGNORE = 4'b1000
  } sep_state_t;
endpackage
`default_nettype wire

/* File: logic/sep_access.sv */
// Serial memory slave with status register, block guards and identification page.
`timescale 1ns/10ps
`default_nettype none
`include "sep_regs.svh"
// How it works
// - Busy status bit 0 stays 1 through the internal write cycle, host cannot write it.
// - Write-enable command sets the latch, write-disable clears it; latch is status bit 1.
// - Two guard bits protect none, upper quarter, upper half or whole array.
// - Guard bits change only by status write and survive power loss.
// - Fast program select is volatile, set by status write, picks cycle length.
// - Guard pin low with pin enable set blocks status writes.
// - Guarded blocks never written; latch 0 blocks all; memory writes ignore the guard pin.
// - Page select routes access to identification page and clears after use.
// - Page lock is nonvolatile and makes the identification page read-only forever.
// - Setting page select and lock together leaves both unchanged.
// - Status write changes bits 7 to 2 only.
// - Memory write is opcode, 24-bit address, data; only low 18 bits decoded.
// - Programming starts at select rise; meanwhile only status read is honoured.
// - Page load increments in-page byte only, wrapping within the 256-byte page.
// - End of internal write cycle clears the write enable latch.
// - Identification writes use address bits 7:0 and obey guard ranges.
// - Identification writes rejected while page lock is set.
// - Guard pin fall during a selected status write aborts it when pin enable is set.
// - Read streams bytes from address, incrementing and wrapping top to zero.
// - Write enable latch is clear after power-up.
// - Opcodes 06h, 04h, 05h for enable, disable and status read.
// - Opcodes 01h, 03h, 02h for status write, read, write; others ignored.
// - Input sampled on clock rise, output shifted on fall, released while deselected.
// - Completed status write also clears the write enable latch.
module sep_access #(
  parameter int WC_STD_CYC  = `SEP_WC_STD_MS * `SEP_CLK_KHZ,
  parameter int WC_FAST_CYC = `SEP_WC_FAST_MS * `SEP_CLK_KHZ
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic sck,
  input  wire logic cs_n,
  input  wire logic si,
  input  wire logic wp_n,
  output var  logic so,
  output var  logic so_oe,
  output var  logic busy
);
  import sep_pkg::*;

  function automatic logic guarded(input logic [1:0] bg, input logic [17:0] a);
    case (bg)
      `SEP_BG_QUARTER: guarded = (a >= `SEP_QTR_BASE);
      `SEP_BG_HALF:    guarded = (a >= `SEP_HALF_BASE);
      `SEP_BG_FULL:    guarded = 1'b1;
      default:         guarded = 1'b0;
    endcase
  endfunction

  sep_pins_t          s1_reg, s2_reg, s3_reg, lvl_reg, prv_reg;
  sep_state_t         state_reg;
  sep_status_t        stat_view;
  logic [4:0]         bitcnt_reg;
  logic [7:0]         rx_reg, rx_next, srdata_reg, wr_idx_reg, tx_reg;
  logic [23:0]        addr_reg, addr_next;
  logic [2:0]         txcnt_reg;
  logic               cmd_read_reg, got_data_reg, abort_reg;
  logic               wr_latch_reg, page_sel_reg, fast_reg, busy_reg, commit_en_reg, wr_id_reg;
  logic               gpe_reg = 1'b0;
  logic               lock_reg = 1'b0;
  logic [1:0]         bg_reg = 2'h0;
  logic [`SEP_CYC_W-1:0] cyc_reg;
  logic [8:0]         commit_idx_reg;
  logic [9:0]         wr_page_reg;
  logic [255:0]       mask_reg;
  logic [7:0]         page_buf [0:255];
  logic [7:0]         mem_main [0:`SEP_ARRAY_TOP];
  logic [7:0]         mem_id   [0:255];
  logic [7:0]         fifo_mem [0:1];
  logic [1:0]         fifo_cnt_reg;
  logic               fifo_wp_reg, fifo_rp_reg, fetch_on_reg;
  logic [17:0]        rd_addr_reg;
  logic [3:0]         agree;
  logic               sck_rise, sck_fall, cs_fall, cs_rise, wp_fall, selected;
  logic               op_done, addr_done, wbyte_ev, hw_prot, data_ok, stat_ok, start_wc;
  logic               end_wc, mem_we, push, pop, tx_load;
  logic [7:0]         tx_byte;

  // Three-stage sampling; a level is taken once the second and third stages agree.
  assign agree = ~(s2_reg ^ s3_reg);
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg  <= `SEP_PINS_IDLE;
      s2_reg  <= `SEP_PINS_IDLE;
      s3_reg  <= `SEP_PINS_IDLE;
      lvl_reg <= `SEP_PINS_IDLE;
      prv_reg <= `SEP_PINS_IDLE;
    end else begin
      s1_reg  <= {sck, cs_n, si, wp_n};
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      lvl_reg <= (lvl_reg & ~agree) | (s2_reg & agree);
      prv_reg <= lvl_reg;
    end
  end

  assign sck_rise = lvl_reg.sck & ~prv_reg.sck;
  assign sck_fall = ~lvl_reg.sck & prv_reg.sck;
  assign cs_fall  = ~lvl_reg.cs_n & prv_reg.cs_n;
  assign cs_rise  = lvl_reg.cs_n & ~prv_reg.cs_n;
  assign wp_fall  = ~lvl_reg.wp_n & prv_reg.wp_n;
  assign selected = ~lvl_reg.cs_n & ~cs_fall;
  assign rx_next   = {rx_reg[6:0], lvl_reg.si};
  assign addr_next = {addr_reg[22:0], lvl_reg.si};
  assign op_done   = sck_rise && selected && state_reg == ST_OP
                     && bitcnt_reg == `SEP_LAST_BYTE_BIT;
  assign addr_done = sck_rise && selected && state_reg == ST_ADDR
                     && bitcnt_reg == `SEP_LAST_ADDR_BIT;
  assign wbyte_ev  = sck_rise && selected && state_reg == ST_WDATA
                     && bitcnt_reg == `SEP_LAST_BYTE_BIT;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg    <= ST_IDLE;
      bitcnt_reg   <= 5'h00;
      rx_reg       <= 8'h00;
      addr_reg     <= 24'h000000;
      cmd_read_reg <= 1'b0;
    end else if (cs_fall) begin
      state_reg  <= ST_OP;
      bitcnt_reg <= 5'h00;
    end else if (cs_rise) begin
      state_reg <= ST_IDLE;
    end else if (sck_rise && selected) begin
      rx_reg <= rx_next;
      if (bitcnt_reg == ((state_reg == ST_ADDR) ? `SEP_LAST_ADDR_BIT : `SEP_LAST_BYTE_BIT))
        bitcnt_reg <= 5'h00;
      else
        bitcnt_reg <= bitcnt_reg + 5'h01;
      case (state_reg)
        ST_OP: begin
          if (bitcnt_reg == `SEP_LAST_BYTE_BIT) begin
            if (busy_reg && rx_next != `SEP_OP_STAT_RD)
              state_reg <= ST_IGNORE;
            else begin
              case (rx_next)
                `SEP_OP_WR_ENABLE: state_reg <= ST_CMD_WRITE_ENABLE;
                `SEP_OP_STAT_RD:   state_reg <= ST_SRDATA;
                `SEP_OP_STAT_WR:   state_reg <= ST_SRWR;
                `SEP_OP_READ: begin
                  state_reg    <= ST_ADDR;
                  cmd_read_reg <= 1'b1;
                end
                `SEP_OP_WRITE: begin
                  state_reg    <= ST_ADDR;
                  cmd_read_reg <= 1'b0;
                end
                default: state_reg <= ST_IGNORE;
              endcase
            end
          end
        end
        ST_ADDR: begin
          addr_reg <= addr_next;
          if (bitcnt_reg == `SEP_LAST_ADDR_BIT)
            state_reg <= cmd_read_reg ? ST_RDATA : ST_WDATA;
        end
        // Extra clocks after the enable byte void it.
        ST_CMD_WRITE_ENABLE: state_reg <= ST_IGNORE;
        default: state_reg <= state_reg;
      endcase
    end
  end

  // Page load with in-page wrap; page from low 18 address bits.
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_idx_reg   <= 8'h00;
      mask_reg     <= '0;
      got_data_reg <= 1'b0;
      srdata_reg   <= 8'h00;
    end else if (cs_fall) begin
      got_data_reg <= 1'b0;
    end else if (addr_done && !cmd_read_reg) begin
      wr_idx_reg <= addr_next[7:0];
      mask_reg   <= '0;
    end else if (wbyte_ev) begin
      page_buf[wr_idx_reg] <= rx_next;
      mask_reg[wr_idx_reg] <= 1'b1;
      wr_idx_reg           <= wr_idx_reg + 8'h01;
      got_data_reg         <= 1'b1;
    end else if (sck_rise && selected && state_reg == ST_SRWR
                 && bitcnt_reg == `SEP_LAST_BYTE_BIT && !got_data_reg) begin
      srdata_reg   <= rx_next;
      got_data_reg <= 1'b1;
    end
  end

  // Guard pin fall while selected aborts the pending status write if pin enable is set.
  always_ff @(posedge clk) begin
    if (rst || cs_fall)
      abort_reg <= 1'b0;
    else if (wp_fall && selected && state_reg == ST_SRWR && gpe_reg)
      abort_reg <= 1'b1;
  end

  assign hw_prot  = gpe_reg & ~lvl_reg.wp_n;
  assign data_ok  = state_reg == ST_WDATA && bitcnt_reg == 5'h00 && got_data_reg
                    && wr_latch_reg && !busy_reg
                    && (page_sel_reg ? (!lock_reg && !guarded(bg_reg, {10'h000, addr_reg[7:0]}))
                                     : !guarded(bg_reg, addr_reg[17:0]));
  assign stat_ok  = state_reg == ST_SRWR && bitcnt_reg == 5'h00 && got_data_reg
                    && wr_latch_reg && !hw_prot && !abort_reg;
  assign start_wc = cs_rise && (data_ok || stat_ok);
  assign end_wc   = busy_reg && cyc_reg == `SEP_CYC_W'(1);

  // Self-timed cycle, length picked by fast program select.
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_reg       <= 1'b0;
      cyc_reg        <= '0;
      commit_idx_reg <= 9'h000;
      commit_en_reg  <= 1'b0;
      wr_id_reg      <= 1'b0;
      wr_page_reg    <= 10'h000;
    end else if (start_wc) begin
      busy_reg       <= 1'b1;
      cyc_reg        <= fast_reg ? `SEP_CYC_W'(WC_FAST_CYC) : `SEP_CYC_W'(WC_STD_CYC);
      commit_idx_reg <= 9'h000;
      commit_en_reg  <= data_ok;
      wr_id_reg      <= page_sel_reg;
      wr_page_reg    <= addr_reg[17:8];
    end else if (busy_reg) begin
      cyc_reg <= cyc_reg - `SEP_CYC_W'(1);
      if (end_wc)
        busy_reg <= 1'b0;
      if (!commit_idx_reg[8])
        commit_idx_reg <= commit_idx_reg + 9'h001;
    end
  end

  assign mem_we = busy_reg && commit_en_reg && !commit_idx_reg[8]
                  && mask_reg[commit_idx_reg[7:0]];
  // Commit loaded bytes to the array or the identification page.
  always_ff @(posedge clk) begin
    if (mem_we) begin
      if (wr_id_reg)
        mem_id[commit_idx_reg[7:0]] <= page_buf[commit_idx_reg[7:0]];
      else
        mem_main[{wr_page_reg, commit_idx_reg[7:0]}] <= page_buf[commit_idx_reg[7:0]];
    end
  end

  always_ff @(posedge clk) begin
    if (rst)
      wr_latch_reg <= 1'b0;
    else if (end_wc)
      wr_latch_reg <= 1'b0;
    else if (cs_rise && state_reg == ST_CMD_WRITE_ENABLE && bitcnt_reg == 5'h00)
      wr_latch_reg <= 1'b1;
    else if (op_done && !busy_reg && rx_next == `SEP_OP_WR_DISABLE)
      wr_latch_reg <= 1'b0;
  end

  // Status write touches bits 7 to 2 only.
  always_ff @(posedge clk) begin
    if (rst) begin
      page_sel_reg <= 1'b0;
      fast_reg     <= 1'b0;
    end else if (cs_rise && stat_ok) begin
      fast_reg <= srdata_reg[`SEP_ST_FAST];
      gpe_reg  <= srdata_reg[`SEP_ST_GPE];
      bg_reg   <= {srdata_reg[`SEP_ST_BG_HI], srdata_reg[`SEP_ST_BG_LO]};
      if (!(srdata_reg[`SEP_ST_PAGE_SEL] && srdata_reg[`SEP_ST_LOCK])) begin
        page_sel_reg <= srdata_reg[`SEP_ST_PAGE_SEL];
        lock_reg     <= lock_reg | srdata_reg[`SEP_ST_LOCK];
      end
    // Page select clears after an identification read or write.
    end else if ((end_wc && commit_en_reg && wr_id_reg)
                 || (cs_rise && state_reg == ST_RDATA)) begin
      page_sel_reg <= 1'b0;
    end
  end

  assign stat_view = '{guard_pin_enable: gpe_reg, id_page_select: page_sel_reg,
                       fast_program_select: fast_reg, id_page_lock: lock_reg,
                       block_guard_hi: bg_reg[1], block_guard_lo: bg_reg[0],
                       write_enable_latch: wr_latch_reg, busy: busy_reg};

  // Read prefetch into a two-entry buffer; stops at select rise.
  assign push = fetch_on_reg && fifo_cnt_reg != `SEP_FIFO_DEPTH;
  assign pop  = tx_load && state_reg == ST_RDATA && fifo_cnt_reg != 2'h0;
  always_ff @(posedge clk) begin
    if (rst || cs_fall || cs_rise) begin
      fetch_on_reg <= 1'b0;
      fifo_cnt_reg <= 2'h0;
      fifo_wp_reg  <= 1'b0;
      fifo_rp_reg  <= 1'b0;
      rd_addr_reg  <= 18'h00000;
    end else begin
      if (addr_done && cmd_read_reg) begin
        fetch_on_reg <= 1'b1;
        rd_addr_reg  <= addr_next[17:0];
      end else if (push) begin
        fifo_mem[fifo_wp_reg] <= page_sel_reg ? mem_id[rd_addr_reg[7:0]] : mem_main[rd_addr_reg];
        fifo_wp_reg           <= ~fifo_wp_reg;
        if (page_sel_reg)
          rd_addr_reg[7:0] <= rd_addr_reg[7:0] + 8'h01;
        else
          rd_addr_reg <= (rd_addr_reg == `SEP_ARRAY_TOP) ? 18'h00000 : rd_addr_reg + 18'h00001;
      end
      if (pop)
        fifo_rp_reg <= ~fifo_rp_reg;
      fifo_cnt_reg <= fifo_cnt_reg + {1'b0, push && !addr_done} - {1'b0, pop};
    end
  end

  // Output shifts on clock fall, MSB first; released when deselected.
  assign tx_load = sck_fall && selected && txcnt_reg == 3'h0;
  assign tx_byte = (state_reg == ST_RDATA) ? fifo_mem[fifo_rp_reg] : stat_view;
  always_ff @(posedge clk) begin
    if (rst || cs_fall) begin
      txcnt_reg <= 3'h0;
      tx_reg    <= 8'h00;
      so        <= 1'b0;
    end else if (sck_fall && selected && (state_reg == ST_RDATA || state_reg == ST_SRDATA)) begin
      txcnt_reg <= txcnt_reg + 3'h1;
      if (txcnt_reg == 3'h0) begin
        so     <= tx_byte[7];
        tx_reg <= {tx_byte[6:0], 1'b0};
      end else begin
        so     <= tx_reg[7];
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      so_oe <= 1'b0;
      busy  <= 1'b0;
    end else begin
      so_oe <= selected && (state_reg == ST_RDATA || state_reg == ST_SRDATA);
      busy  <= busy_reg;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence wc_start_s;
    $rose(busy_reg);
  endsequence
  sequence cmd_write_enable_end_s;
    cs_rise && state_reg == ST_CMD_WRITE_ENABLE && bitcnt_reg == 5'h00;
  endsequence

  busy_hold_a: assert property (wc_start_s |-> busy_reg[*8])
    else $error("Busy dropped early.");
  latch_set_a: assert property (cmd_write_enable_end_s |=> wr_latch_reg)
    else $error("Write enable latch not set.");
  guard_write_a: assert property (mem_we && !wr_id_reg |->
    !guarded(bg_reg, {wr_page_reg, commit_idx_reg[7:0]}))
    else $error("Guarded block written.");
  id_lock_a: assert property (mem_we && wr_id_reg |-> !lock_reg)
    else $error("Locked page written.");
  both_bits_a: assert property (cs_rise && stat_ok
    && srdata_reg[`SEP_ST_PAGE_SEL] && srdata_reg[`SEP_ST_LOCK]
    |=> $stable(page_sel_reg) && $stable(lock_reg))
    else $error("Select and lock changed together.");
  stat_low_a: assert property (cs_rise && stat_ok
    |=> wr_latch_reg == $past(wr_latch_reg))
    else $error("Status write touched low bits.");
  busy_ignore_a: assert property (op_done && busy_reg && rx_next != `SEP_OP_STAT_RD
    |=> state_reg == ST_IGNORE)
    else $error("Command taken while busy.");
  page_wrap_a: assert property (wbyte_ev |=> wr_idx_reg == $past(wr_idx_reg) + 8'h01)
    else $error("Page index did not step.");
  latch_end_a: assert property ($fell(busy_reg) |-> !wr_latch_reg)
    else $error("Latch survived write cycle.");
  wp_abort_a: assert property (wp_fall && selected && state_reg == ST_SRWR && gpe_reg
    |=> abort_reg ##0 !stat_ok)
    else $error("Guard pin fall not aborting.");
  read_wrap_a: assert property (push && !addr_done && !page_sel_reg
    && rd_addr_reg == `SEP_ARRAY_TOP |=> rd_addr_reg == 18'h00000)
    else $error("Read address did not wrap.");
  so_hiz_a: assert property (lvl_reg.cs_n [*2] |-> !so_oe)
    else $error("Output driven while deselected.");
  no_latch_a: assert property (wc_start_s |-> $past(wr_latch_reg))
    else $error("Cycle started without latch.");
endmodule
`default_nettype wire

/* File: verif/sep_host_model.sv */
// Behavioural serial host that drives the memory link in mode 0.
`timescale 1ns/10ps
`default_nettype none
module sep_host_model (
  output var  logic sck,
  output var  logic cs_n,
  output var  logic si,
  input  wire logic so_w
);
  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    si   = 1'b1;
  end

  // The clock stands low between frames and the data line shows the inverse of its last bit.
  task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    cs_n = 1'b0;
    #62.5;
    foreach (tx[i]) begin
      for (int k = 7; k >= 0; k--) begin
        si = tx[i][k];
        #62.5 sck = 1'b1;
        b[k] = so_w;
        #62.5 sck = 1'b0;
      end
      rx.push_back(b);
    end
    #62.5 cs_n = 1'b1;
    si = ~si;
    #200;
  endtask
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench for the serial memory block driven over its serial link.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb;
  import sep_pkg::*;
  localparam int          STD    = 1000;
  localparam int          FAST   = 500;
  localparam logic [23:0] LO [4] = '{24'h0, 24'h030000, 24'h020000, 24'h000000};
  logic       clk       = 1'b0;
  logic       rst       = 1'b1;
  logic       wp_n      = 1'b1;
  wire  logic sck;
  wire  logic cs_n;
  wire  logic si;
  wire  logic so;
  wire  logic so_oe;
  wire  logic busy;
  wire  logic so_w      = so_oe ? so : 1'bz;
  int         n_errors  = 0;
  int         tests_run = 0;
  int         n;
  logic [7:0] rx[$];

  always #5 clk = ~clk;

  sep_host_model host (.sck(sck), .cs_n(cs_n), .si(si), .so_w(so_w));
  sep_access #(.WC_STD_CYC(STD), .WC_FAST_CYC(FAST)) uut (
    .clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n),
    .so(so), .so_oe(so_oe), .busy(busy)
  );

  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic go(input logic [7:0] tx[$]);
    host.frame(tx, rx);
  endtask

  // Counts busy cycles after a frame; zero means no write cycle was started.
  task automatic cyc(output int c);
    c = 0;
    repeat (40) begin
      @(negedge clk);
      if (busy === 1'b1) c++;
    end
    while (busy === 1'b1 && c < 3000) begin
      @(negedge clk);
      c++;
    end
    if (c >= 3000) begin
      n_errors++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [23:0] a, input logic [7:0] d[$], output int c);
    logic [7:0] tx[$];
    tx = {8'h02, a[23:16], a[15:8], a[7:0]};
    tx = {tx, d};
    go({8'h06});
    go(tx);
    cyc(c);
  endtask

  task automatic cmd_status_write(input logic [7:0] v);
    go({8'h06});
    go({8'h01, v});
    cyc(n);
  endtask

  task automatic st(input logic [7:0] e, input string nm);
    go({8'h05, 8'h00});
    `CHK(nm, e, rx[1])
  endtask

  task automatic rd(input logic [23:0] a);
    go({8'h03, a[23:16], a[15:8], a[7:0], 8'h00, 8'h00});
  endtask

  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    repeat (10) @(negedge clk);
    `CHK("so_oe idle", 1'b0, so_oe)
    st(8'h00, "reset status");
    // The write frame goes out alone so that the latch is still clear.
    go({8'h02, 8'h00, 8'h00, 8'h10, 8'h5a});
    cyc(n);
    `CHK("write without latch", 0, n)
    go({8'h06});
    st(8'h02, "latch set");
    go({8'h04});
    st(8'h00, "latch clear");
    go({8'h06, 8'h00});
    st(8'h00, "late select");
    go({8'ha5});
    st(8'h00, "unknown opcode");
    go({8'h06});
    go({8'h02, 8'hfc, 8'h01, 8'hfe, 8'ha0, 8'ha1, 8'ha2, 8'ha3});
    st(8'h03, "busy status");
    go({8'h04});
    st(8'h03, "ignored in cycle");
    cyc(n);
    st(8'h00, "latch after cycle");
    rd(24'h000100);
    `CHK("page wrap", 16'ha2a3, {rx[4], rx[5]})
    rd(24'hfc01fe);
    `CHK("upper bits ignored", 16'ha0a1, {rx[4], rx[5]})
    `CHK("output released", 1'b0, so_oe)
    wr(24'h03ffff, {8'h11}, n);
    `CHK("standard length", 1'b1, n > 750)
    wr(24'h000000, {8'h22}, n);
    rd(24'h03ffff);
    `CHK("array wrap", 16'h1122, {rx[4], rx[5]})
    cmd_status_write(8'h23);
    st(8'h20, "status write");
    wr(24'h000000, {8'h33}, n);
    `CHK("fast length", 1'b1, n > 0 && n < 750)
    for (int g = 1; g < 4; g++) begin
      cmd_status_write(8'(g << 2));
      st(8'(g << 2), "guard bits");
      wr(LO[g], {8'h44}, n);
      `CHK("guarded write", 0, n)
      if (g < 3) begin
        wr(LO[g] - 24'h1, {8'h55}, n);
        `CHK("open write", 1'b1, n > 0)
      end
    end
    cmd_status_write(8'h4c);
    wr(24'h000010, {8'h66}, n);
    `CHK("id write full guard", 0, n)
    cmd_status_write(8'h40);
    wr(24'hffff10, {8'h5c}, n);
    st(8'h00, "select after write");
    cmd_status_write(8'h40);
    rd(24'h000010);
    `CHK("id page read", 8'h5c, rx[4])
    st(8'h00, "select after read");
    cmd_status_write(8'h80);
    @(negedge clk) wp_n = 1'b0;
    cmd_status_write(8'h84);
    `CHK("pin guarded status", 0, n)
    go({8'h04});
    st(8'h80, "guard kept");
    @(negedge clk) wp_n = 1'b1;
    go({8'h06});
    fork
      go({8'h01, 8'h84});
      // The pin dips inside the data byte and is back up before select rises.
      begin
        repeat (150) @(negedge clk);
        wp_n = 1'b0;
        repeat (30) @(negedge clk);
        wp_n = 1'b1;
      end
    join
    cyc(n);
    `CHK("pin fall aborts", 0, n)
    @(negedge clk) wp_n = 1'b1;
    go({8'h04});
    st(8'h80, "after abort");
    cmd_status_write(8'h00);
    st(8'h00, "pin high writable");
    cmd_status_write(8'h50);
    st(8'h00, "select with lock");
    cmd_status_write(8'h10);
    st(8'h10, "lock set");
    cmd_status_write(8'h44);
    wr(24'h000010, {8'h99}, n);
    `CHK("locked id write", 0, n)
    @(negedge clk) rst = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (10) @(negedge clk);
    st(8'h14, "kept over reset");
    complete_run();
  end
endmodule
`default_nettype wire
